// [rtl/wlx_exec.sv]
// Purpose: execute word loads and cross-halfword multiply-accumulates
// Assumes: one instruction in flight; issue only while ready_out is high
// Notes:   operands are read a cycle after issue; results retire one at a time
// Notes on behaviour
// - indexed address is index plus base-or-zero
// - displacement sign-extended before adding base
// - update forms write address into base
// - loaded word goes to target unchanged
// - indexed bit31 leaves condition field undefined
// - only reserve load sets reservation flag
// - conditional store clears flag, reports store outcome in equal bit
// - reserve load misaligned raises alignment exception
// - byte-reversed load swaps byte order
// - zero-count string fill bus error: machine check
// - multiply low half first by high second
// - modulo forms keep low 32 sum bits
// - signed saturate toward old target sign
// - unsigned saturate to all ones above max
// - record and overflow-enable flag updates
module wlx_exec
	import wlx_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        issue_in,
	input  wire instr_s      instr_in,
	output logic             ready_out,
	output mem_req_s         mem_req_out,
	input  wire mem_rsp_s    mem_rsp_in,
	output logic             align_exc_out,
	output logic             mcheck_out,
	output logic             reserve_out,
	output logic [3:0]       primary_condition_field_out,
	output logic [1:0]       fixed_point_exception_reg_out,
	output logic             done_out
);

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_READ,
		ST_EXEC,
		ST_MEM,
		ST_WB_BASE
	} state_e;

	typedef struct packed
	{
		state_e        state;
		instr_s        ins;
		logic [31:0]   ea;
		logic [31:0]   load_data;
		logic          reserve;
		logic [3:0]    cond;
		logic [1:0]    fixed_point_exception_reg;
		logic          align_exc;
		logic          mcheck;
		logic          done;
		mem_req_s      req;
		logic          wr_en;
		logic [4:0]    wr_idx;
		logic [31:0]   wr_data;
	} exec_s;

	exec_s       st_r;
	exec_s       st_nxt;
	logic [31:0] base_val;
	logic [31:0] index_val;
	logic [31:0] target_val;

	gpr_file #(
		.DEPTH (GPR_CNT),
		.IDX_W (GPR_IDX_W)
	) u_gpr (
		.clk_sys_in  (clk_sys_in),
		.rd_a_idx_in (st_r.ins.base_gpr),
		.rd_b_idx_in (st_r.ins.index_gpr),
		.rd_c_idx_in (st_r.ins.target_gpr),
		.rd_a_out    (base_val),
		.rd_b_out    (index_val),
		.rd_c_out    (target_val),
		.wr_en_in    (st_r.wr_en),
		.wr_idx_in   (st_r.wr_idx),
		.wr_data_in  (st_r.wr_data)
	);

	function automatic logic [31:0] base_or_zero(input logic [4:0] idx, input logic [31:0] v);
		base_or_zero = (idx == GPR_ZERO) ? WORD_ZERO : v;
	endfunction

	function automatic logic [3:0] cond_of(input logic [31:0] r, input logic so);
		logic [3:0] c;
		c = COND_RESET;
		c[COND_LT] = r[31];
		c[COND_GT] = ~r[31] && (r != WORD_ZERO);
		c[COND_EQ] = (r == WORD_ZERO);
		c[COND_SO] = so;
		cond_of = c;
	endfunction

	logic        is_signed;
	logic [16:0] mul_a;
	logic [16:0] mul_b;
	logic [33:0] prod_full;
	logic [31:0] prod;
	logic [32:0] sum;
	logic [31:0] mac_res;
	logic        mac_ov;
	logic        so_new;

	always_comb
	begin
		is_signed = (st_r.ins.op == OP_MAC_MOD_S) || (st_r.ins.op == OP_MAC_SAT_S);
		// low half of first source times high half of second
		mul_a = {is_signed & base_val[15], base_val[15:0]};
		mul_b = {is_signed & index_val[31], index_val[31:16]};
		prod_full = 34'($signed(mul_a) * $signed(mul_b));
		prod = prod_full[31:0];
		sum = {1'b0, prod} + {1'b0, target_val};
		mac_res = sum[31:0];
		mac_ov = 1'b0;
		case (st_r.ins.op)
			OP_MAC_SAT_S:
			begin
				mac_ov = (prod[31] == target_val[31]) && (target_val[31] != sum[31]);
				if (mac_ov)
				begin
					mac_res = target_val[31] ? SAT_NEG : SAT_POS;
				end
			end
			OP_MAC_SAT_U:
			begin
				mac_ov = sum[32];
				if (mac_ov)
				begin
					mac_res = SAT_UNS;
				end
			end
			OP_MAC_MOD_S:
			begin
				// modulo overflow: signed sum leaves 32-bit range
				mac_ov = (prod[31] == target_val[31]) && (target_val[31] != sum[31]);
			end
			OP_MAC_MOD_U:
			begin
				mac_ov = sum[32];
			end
			default:
			begin
				mac_ov = 1'b0;
			end
		endcase
		so_new = st_r.fixed_point_exception_reg[XER_SO] | (st_r.ins.oe_bit & mac_ov);
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.align_exc = 1'b0;
		st_nxt.mcheck = 1'b0;
		st_nxt.wr_en = 1'b0;
		st_nxt.req.valid = 1'b0;
		case (st_r.state)
			ST_IDLE:
			begin
				if (issue_in && (instr_in.op != OP_NONE))
				begin
					st_nxt.ins = instr_in;
					st_nxt.state = ST_READ;
				end
			end
			ST_READ:
			begin
				// register file captures read data at the end of this cycle; they are valid in ST_EXEC
				st_nxt.state = ST_EXEC;
			end
			ST_EXEC:
			begin
				st_nxt.state = ST_IDLE;
				st_nxt.done = 1'b1;
				case (st_r.ins.op)
					OP_LOAD_DISP, OP_LOAD_DISP_UPD:
					begin
						st_nxt.ea = base_or_zero(st_r.ins.base_gpr, base_val)
							+ {{(WORD_W-DISP_W){st_r.ins.disp[15]}}, st_r.ins.disp};
						st_nxt.req.valid = 1'b1;
						st_nxt.req.effective_address = st_nxt.ea;
						st_nxt.state = ST_MEM;
						st_nxt.done = 1'b0;
					end
					OP_LOAD_IDX, OP_LOAD_IDX_UPD, OP_LOAD_RESERVE, OP_LOAD_BYTEREV:
					begin
						st_nxt.ea = base_or_zero(st_r.ins.base_gpr, base_val) + index_val;
						if ((st_r.ins.op == OP_LOAD_RESERVE) && (st_nxt.ea[1:0] != WORD_ALIGN_0))
						begin
							st_nxt.align_exc = 1'b1;
						end
						else
						begin
							st_nxt.req.valid = 1'b1;
							st_nxt.req.effective_address = st_nxt.ea;
							st_nxt.state = ST_MEM;
							st_nxt.done = 1'b0;
						end
					end
					OP_STORE_COND:
					begin
						// store path lives elsewhere; only flag and outcome here
						st_nxt.reserve = 1'b0;
						st_nxt.cond = {2'b00, st_r.ins.cond_store_ok, st_r.fixed_point_exception_reg[XER_SO]};
					end
					OP_STRING_ZERO:
					begin
						st_nxt.ea = base_or_zero(st_r.ins.base_gpr, base_val) + index_val;
						st_nxt.req.valid = 1'b1;
						st_nxt.req.effective_address = st_nxt.ea;
						st_nxt.state = ST_MEM;
						st_nxt.done = 1'b0;
					end
					OP_MAC_MOD_S, OP_MAC_MOD_U, OP_MAC_SAT_S, OP_MAC_SAT_U:
					begin
						st_nxt.wr_en = 1'b1;
						st_nxt.wr_idx = st_r.ins.target_gpr;
						st_nxt.wr_data = mac_res;
						if (st_r.ins.oe_bit)
						begin
							st_nxt.fixed_point_exception_reg = {so_new, mac_ov};
						end
						if (st_r.ins.record_bit)
						begin
							st_nxt.cond = cond_of(mac_res, so_new);
						end
					end
					default:
					begin
						st_nxt.state = ST_IDLE;
					end
				endcase
			end
			ST_MEM:
			begin
				if (mem_rsp_in.valid)
				begin
					st_nxt.done = 1'b1;
					st_nxt.state = ST_IDLE;
					if (st_r.ins.op == OP_STRING_ZERO)
					begin
						// zero count: no register changes, only the fill error matters
						st_nxt.mcheck = mem_rsp_in.prot_ok && mem_rsp_in.cacheable
							&& mem_rsp_in.cache_miss && mem_rsp_in.bus_err;
					end
					else
					begin
						st_nxt.wr_en = 1'b1;
						st_nxt.wr_idx = st_r.ins.target_gpr;
						st_nxt.wr_data = mem_rsp_in.data;
						if (st_r.ins.op == OP_LOAD_BYTEREV)
						begin
							st_nxt.wr_data = {mem_rsp_in.data[7:0], mem_rsp_in.data[15:8],
								mem_rsp_in.data[23:16], mem_rsp_in.data[31:24]};
						end
						if (st_r.ins.op == OP_LOAD_RESERVE)
						begin
							st_nxt.reserve = 1'b1;
						end
						// the update form clears it with its base write, so cond moves only at done
						if (st_r.ins.bit31 && (st_r.ins.op != OP_LOAD_DISP)
							&& (st_r.ins.op != OP_LOAD_DISP_UPD)
							&& (st_r.ins.op != OP_LOAD_IDX_UPD))
						begin
							// undefined is allowed; cleared keeps it deterministic
							st_nxt.cond = COND_RESET;
						end
						if ((st_r.ins.op == OP_LOAD_DISP_UPD) || (st_r.ins.op == OP_LOAD_IDX_UPD))
						begin
							st_nxt.state = ST_WB_BASE;
							st_nxt.done = 1'b0;
						end
					end
				end
			end
			ST_WB_BASE:
			begin
				// single write port, so base update follows the target write
				st_nxt.wr_en = 1'b1;
				st_nxt.wr_idx = st_r.ins.base_gpr;
				st_nxt.wr_data = st_r.ea;
				if (st_r.ins.bit31 && (st_r.ins.op == OP_LOAD_IDX_UPD))
				begin
					st_nxt.cond = COND_RESET;
				end
				st_nxt.done = 1'b1;
				st_nxt.state = ST_IDLE;
			end
			default:
			begin
				st_nxt.state = ST_IDLE;
			end
		endcase
		if (rst_in)
		begin
			st_nxt = '0;
			st_nxt.state = ST_IDLE;
			st_nxt.cond = COND_RESET;
			st_nxt.fixed_point_exception_reg = XER_RESET;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		st_r <= st_nxt;
		ready_out <= (st_nxt.state == ST_IDLE) && !rst_in;
		mem_req_out <= st_nxt.req;
		align_exc_out <= st_nxt.align_exc;
		mcheck_out <= st_nxt.mcheck;
		reserve_out <= st_nxt.reserve;
		primary_condition_field_out <= st_nxt.cond;
		fixed_point_exception_reg_out <= st_nxt.fixed_point_exception_reg;
		done_out <= st_nxt.done;
	end

endmodule

// [rtl/wlx_pkg.sv]
// Purpose: shared constants and carriers for the word-load and cross-mac unit
// Assumes: big-endian bit numbering maps to [31:0] with bit 0 as msb
// Notes:   the memory side answers one word per request
package wlx_pkg;

	localparam int          WORD_W        = 32;
	localparam int          GPR_CNT       = 32;
	localparam int          GPR_IDX_W     = 5;
	localparam int          DISP_W        = 16;
	localparam logic [4:0]  GPR_ZERO      = 5'h00;
	localparam logic [1:0]  WORD_ALIGN_0  = 2'h0;
	localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
	localparam logic [31:0] SAT_POS       = 32'h7FFF_FFFF;
	localparam logic [31:0] SAT_NEG       = 32'h8000_0000;
	localparam logic [31:0] SAT_UNS       = 32'hFFFF_FFFF;
	localparam logic [3:0]  COND_RESET    = 4'h0;
	localparam logic [1:0]  XER_RESET     = 2'h0;
	localparam int          COND_LT       = 3;
	localparam int          COND_GT       = 2;
	localparam int          COND_EQ       = 1;
	localparam int          COND_SO       = 0;
	localparam int          XER_SO        = 1;
	localparam int          XER_OV        = 0;

	typedef enum logic [3:0]
	{
		OP_NONE,
		OP_LOAD_DISP,
		OP_LOAD_DISP_UPD,
		OP_LOAD_IDX,
		OP_LOAD_IDX_UPD,
		OP_LOAD_RESERVE,
		OP_LOAD_BYTEREV,
		OP_STORE_COND,
		OP_STRING_ZERO,
		OP_MAC_MOD_S,
		OP_MAC_MOD_U,
		OP_MAC_SAT_S,
		OP_MAC_SAT_U
	} op_e;

	typedef struct packed
	{
		op_e                   op;
		logic [4:0]            target_gpr;
		logic [4:0]            base_gpr;
		logic [4:0]            index_gpr;
		logic [15:0]           disp;
		logic                  record_bit;
		logic                  oe_bit;
		logic                  bit31;
		logic                  cond_store_ok;
	} instr_s;

	typedef struct packed
	{
		logic                  valid;
		logic [31:0]           data;
		logic                  bus_err;
		logic                  cacheable;
		logic                  prot_ok;
		logic                  cache_miss;
	} mem_rsp_s;

	typedef struct packed
	{
		logic                  valid;
		logic [31:0]           effective_address;
	} mem_req_s;

endpackage

// [rtl/gpr_file.sv]
// Purpose: general register file, three read ports registered, one write port
// Assumes: write and read of the same index in one cycle returns the old value
// Notes:   register zero is an ordinary register here; zero-base is decoded outside
module gpr_file
	import wlx_pkg::*;
#(
	parameter int DEPTH  = GPR_CNT,
	parameter int IDX_W  = GPR_IDX_W
)
(
	input  wire logic              clk_sys_in,
	input  wire logic [IDX_W-1:0]  rd_a_idx_in,
	input  wire logic [IDX_W-1:0]  rd_b_idx_in,
	input  wire logic [IDX_W-1:0]  rd_c_idx_in,
	output logic      [31:0]       rd_a_out,
	output logic      [31:0]       rd_b_out,
	output logic      [31:0]       rd_c_out,
	input  wire logic              wr_en_in,
	input  wire logic [IDX_W-1:0]  wr_idx_in,
	input  wire logic [31:0]       wr_data_in
);

	logic [31:0] mem [DEPTH];

	always_ff @(posedge clk_sys_in)
	begin
		if (wr_en_in)
		begin
			mem[wr_idx_in] <= wr_data_in;
		end
		rd_a_out <= mem[rd_a_idx_in];
		rd_b_out <= mem[rd_b_idx_in];
		rd_c_out <= mem[rd_c_idx_in];
	end

endmodule

// [test/wlx_exec_props.sv]
// Purpose: port timing checks for wlx_exec
// Assumes: latencies of the hand-over walk
// Notes:   gpr contents are not visible here
module wlx_exec_props
	import wlx_pkg::*;
(
	input wire logic       clk_sys_in,
	input wire logic       rst_in,
	input wire logic       issue_in,
	input wire instr_s     instr_in,
	input wire logic       ready_out,
	input wire mem_req_s   mem_req_out,
	input wire mem_rsp_s   mem_rsp_in,
	input wire logic       align_exc_out,
	input wire logic       mcheck_out,
	input wire logic       reserve_out,
	input wire logic [3:0] primary_condition_field_out,
	input wire logic [1:0] fixed_point_exception_reg_out,
	input wire logic       done_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic take;
	assign take = issue_in && ready_out;
	chk_load_req_lat: assert property (take && instr_in.op inside {OP_LOAD_DISP, OP_LOAD_IDX,
		OP_LOAD_DISP_UPD, OP_LOAD_IDX_UPD, OP_LOAD_BYTEREV} |-> ##3 mem_req_out.valid)
		else $error("load request late");
	chk_mac_done_lat: assert property (take && instr_in.op inside {OP_MAC_MOD_S, OP_MAC_MOD_U,
		OP_MAC_SAT_S, OP_MAC_SAT_U} |-> !done_out [*3] ##1 done_out)
		else $error("mac done late");
	chk_store_clears: assert property (take && instr_in.op == OP_STORE_COND |-> ##3 done_out
		&& !reserve_out && primary_condition_field_out[COND_EQ] == $past(instr_in.cond_store_ok, 3))
		else $error("store cond outcome");
	chk_rsv_set_done: assert property ($rose(reserve_out) |-> done_out)
		else $error("reservation set off done");
	chk_rsv_clear_done: assert property ($fell(reserve_out) |-> done_out)
		else $error("reservation cleared off done");
	chk_align_no_req: assert property (align_exc_out |-> done_out && !mem_req_out.valid)
		else $error("alignment without done");
	chk_mcheck_cause: assert property (mcheck_out |-> $past(mem_rsp_in.valid &&
		mem_rsp_in.bus_err && mem_rsp_in.cacheable && mem_rsp_in.prot_ok && mem_rsp_in.cache_miss))
		else $error("machine check without cause");
	chk_xer_at_done: assert property ($changed(fixed_point_exception_reg_out) |-> done_out)
		else $error("xer changed off done");
	chk_cond_at_done: assert property ($changed(primary_condition_field_out) |-> done_out)
		else $error("cond changed off done");
endmodule
bind wlx_exec wlx_exec_props chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.issue_in(issue_in), .instr_in(instr_in), .ready_out(ready_out), .mem_req_out(mem_req_out),
	.mem_rsp_in(mem_rsp_in), .align_exc_out(align_exc_out), .mcheck_out(mcheck_out),
	.reserve_out(reserve_out), .primary_condition_field_out(primary_condition_field_out),
	.fixed_point_exception_reg_out(fixed_point_exception_reg_out), .done_out(done_out));

// [test/mem_partner.sv]
// Purpose: data cache and bus side, one word per request
// Assumes: lat_in of at least one cycle
// Notes:   idle data toggles so a stale word never looks valid
module mem_partner
	import wlx_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire mem_req_s    req_in,
	input  wire logic [31:0] data_in,
	input  wire logic        fault_in,
	input  wire logic        miss_in,
	input  wire logic [2:0]  lat_in,
	output mem_rsp_s         rsp_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_r = 3'h0;
	initial rsp_out = '0;
	always @(posedge clk_sys_in)
	begin
		rsp_out.valid <= 1'b0;
		rsp_out.data  <= ~rsp_out.data;
		if (wait_r == 3'h1)
			rsp_out <= '{1'b1, data_in, fault_in, 1'b1, 1'b1, miss_in};
		if (wait_r != 3'h0)
			wait_r <= wait_r - 3'h1;
		if (req_in.valid)
			wait_r <= lat_in;
	end
endmodule

// [test/word_load_and_cross_mac_exec_bench.sv]
// Purpose: self-checking bench for wlx_exec
// Assumes: gpr values are seen as addresses of later indexed loads
// Notes:   partner latency alternates between quick and slow
module word_load_and_cross_mac_exec_bench
	import wlx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 0, rst_in = 1, issue_in = 0, align_exc_out, mcheck_out, reserve_out;
	logic done_out, ready_out, fault = 0, sc_ok = 0, al, mc, miss = 1, b31 = 0;
	logic [3:0] cond;
	logic [1:0] fixed_point_exception_reg;
	logic [31:0] mem_data = 0, ea;
	logic [2:0] lat = 3'h1;
	instr_s instr_in = '0;
	mem_req_s mem_req_out;
	mem_rsp_s mem_rsp_in;
	int err_count = 0, compares = 0;
	wlx_exec dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .issue_in(issue_in),
		.instr_in(instr_in), .ready_out(ready_out), .mem_req_out(mem_req_out),
		.mem_rsp_in(mem_rsp_in), .align_exc_out(align_exc_out), .mcheck_out(mcheck_out),
		.reserve_out(reserve_out), .primary_condition_field_out(cond),
		.fixed_point_exception_reg_out(fixed_point_exception_reg), .done_out(done_out));
	mem_partner mem (.clk_sys_in(clk_sys_in), .req_in(mem_req_out), .data_in(mem_data),
		.fault_in(fault), .miss_in(miss), .lat_in(lat), .rsp_out(mem_rsp_in));
	initial forever #50 clk_sys_in = ~clk_sys_in;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic exec(input op_e op, input logic [4:0] t, a, b, input logic [15:0] d,
		input logic rc, oe, input logic [31:0] data);
		@(posedge clk_sys_in);
		mem_data <= data;
		lat <= (lat == 3'h1) ? 3'h4 : 3'h1;
		instr_in <= '{op, t, a, b, d, rc, oe, b31, sc_ok};
		issue_in <= 1'b1;
		@(posedge clk_sys_in);
		issue_in <= 1'b0;
		ea = 'x;
		al = 0;
		mc = 0;
		do
		begin
			@(negedge clk_sys_in);
			if (mem_req_out.valid === 1'b1)
				ea = mem_req_out.effective_address;
			al |= align_exc_out;
			mc |= mcheck_out;
		end while (done_out !== 1'b1);
		while (ready_out !== 1'b1)
			@(negedge clk_sys_in);
	endtask
	// a register is read back as the address of an indexed load with base zero
	task automatic peek(input logic [4:0] r, input logic [31:0] exp, input string what);
		exec(OP_LOAD_IDX, 5'd31, 5'd0, r, 16'h0, 0, 0, 32'h0);
		check(what, ea, exp);
	endtask
	task automatic t_loads();
		exec(OP_LOAD_DISP, 5'd1, 5'd0, 5'd0, 16'hFFF0, 0, 0, 32'h1234_5678);
		check("disp ea", ea, 32'hFFFF_FFF0);
		exec(OP_LOAD_DISP, 5'd3, 5'd0, 5'd0, 16'h0100, 0, 0, 32'h0000_0100);
		check("base zero ea", ea, 32'h0000_0100);
		peek(5'd1, 32'h1234_5678, "loaded word");
		exec(OP_LOAD_IDX, 5'd2, 5'd3, 5'd1, 16'h0, 0, 0, 32'h0);
		check("indexed ea", ea, 32'h1234_5778);
		exec(OP_LOAD_DISP_UPD, 5'd4, 5'd3, 5'd0, 16'h0008, 0, 0, 32'h0);
		peek(5'd3, 32'h0000_0108, "disp update base");
		exec(OP_LOAD_IDX_UPD, 5'd4, 5'd3, 5'd1, 16'h0, 0, 0, 32'h0);
		peek(5'd3, 32'h1234_5780, "idx update base");
		exec(OP_LOAD_BYTEREV, 5'd5, 5'd0, 5'd1, 16'h0, 0, 0, 32'h1122_3344);
		peek(5'd5, 32'h4433_2211, "reversed word");
		$display("loads finished");
	endtask
	task automatic t_reserve();
		exec(OP_LOAD_DISP, 5'd6, 5'd0, 5'd0, 16'h0020, 0, 0, 32'h0000_0103);
		exec(OP_LOAD_RESERVE, 5'd7, 5'd0, 5'd6, 16'h0, 0, 0, 32'h0);
		check("misaligned exc", 32'(al), 32'h1);
		exec(OP_LOAD_RESERVE, 5'd7, 5'd0, 5'd3, 16'h0, 0, 0, 32'h0);
		check("aligned exc", 32'(al), 32'h0);
		check("reserve set", 32'(reserve_out), 32'h1);
		exec(OP_LOAD_DISP, 5'd8, 5'd0, 5'd0, 16'h0, 0, 0, 32'h0);
		check("reserve kept", 32'(reserve_out), 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			sc_ok = i[0];
			exec(OP_STORE_COND, 5'd8, 5'd0, 5'd0, 16'h0, 1, 0, 32'h0);
			check("reserve clear", 32'(reserve_out), 32'h0);
			check("store eq", 32'(cond[COND_EQ]), 32'(sc_ok));
		end
		$display("reservation finished");
	endtask
	task automatic mac(input op_e op, input logic [31:0] a, b, t, input logic rc, oe,
		input logic [31:0] exp, input string what);
		exec(OP_LOAD_DISP, 5'd10, 5'd0, 5'd0, 16'h0, 0, 0, a);
		exec(OP_LOAD_DISP, 5'd11, 5'd0, 5'd0, 16'h0, 0, 0, b);
		exec(OP_LOAD_DISP, 5'd12, 5'd0, 5'd0, 16'h0, 0, 0, t);
		exec(op, 5'd12, 5'd10, 5'd11, 16'h0, rc, oe, 32'h0);
		peek(5'd12, exp, what);
	endtask
	task automatic t_mac();
		mac(OP_MAC_MOD_S, 32'hFFFF, 32'h2_0000, 32'h5, 1, 0, 32'h3, "mod signed");
		check("cond gt", 32'(cond), 32'h4);
		mac(OP_MAC_MOD_U, 32'hFFFF, 32'hFFFF_0000, 32'h2_0000, 0, 0, 32'h1, "mod uns");
		mac(OP_MAC_SAT_U, 32'hFFFF, 32'hFFFF_0000, 32'h2_0000, 0, 0, SAT_UNS, "sat uns");
		mac(OP_MAC_SAT_S, 32'h8000, 32'h7FFF_0000, SAT_NEG, 0, 0, SAT_NEG, "sat neg");
		mac(OP_MAC_SAT_S, 32'h7FFF, 32'h7FFF_0000, SAT_POS, 1, 1, SAT_POS, "sat pos");
		check("xer ov", 32'(fixed_point_exception_reg), 32'h3);
		check("cond so", 32'(cond), 32'h5);
		b31 = 1;
		exec(OP_LOAD_IDX_UPD, 5'd13, 5'd3, 5'd1, 16'h0, 0, 0, 32'h0);
		check("bit31 cond", 32'(cond), 32'h0);
		b31 = 0;
		$display("mac finished");
	endtask
	task automatic t_string();
		// a bus error on a hit must not raise the check
		for (int i = 0; i < 3; i++)
		begin
			fault = (i != 0);
			miss = (i != 2);
			exec(OP_STRING_ZERO, 5'd9, 5'd0, 5'd1, 16'h0, 0, 0, 32'h0);
			check("machine check", 32'(mc), 32'(i == 1));
		end
		miss = 1;
		$display("string finished");
	endtask
	task automatic end_of_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// generous: 45 operations of under 20 cycles each
	initial
	begin
		repeat (5000) @(posedge clk_sys_in);
		err_count++;
		end_of_test();
	end
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		t_loads();
		t_reserve();
		t_mac();
		t_string();
		end_of_test();
	end
endmodule
